/* File: rtl/acp_top.sv */
// Overview of operation
// - bit 7 chooses high speed or low power
// - bits 6:5 divide clock by 1,2,4,8
// - bit 4 chooses short or long sampling
// - bits 3:2 choose 8 or 10 bit
// - bits 1:0 choose the clock source
// - low pin register covers channels 0 to 7
// - mid pin register covers channels 8 to 15
// - pin bit set removes port control
// - released pin: hiz, no input, no pullup
// - reset selects bus clock as source
// - mode change invalidates result data
//
// Purpose: configuration and analog pin control of the converter
// Assumes: single bus clock, async active low reset
// Notes: alternate and internal clocks enter as pin-level inputs
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module acp_top
(
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic [1:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_ALT_CLK,
  input wire logic I_ASYNC_CLK,
  input wire logic [15:0] I_PORT_OE,
  input wire logic [15:0] I_PORT_PULLUP,
  input wire logic [15:0] I_PIN_IN,
  output logic [15:0] O_PIN_OE,
  output logic [15:0] O_PIN_PULLUP,
  output logic [15:0] O_PIN_IBUF_EN,
  output logic [15:0] O_PORT_RDATA,
  output logic [15:0] O_ANALOG_SEL,
  output logic O_LOW_POWER,
  output logic O_LONG_SAMPLE,
  output logic [1:0] O_MODE,
  output logic O_CONV_CLK_EN,
  output logic O_RESULT_INVALID
);
  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] cfg_r;
  logic [7:0] pin_low_r;
  logic [7:0] pin_mid_r;
  logic invalid_r;
  logic [2:0] alt_sync_r;
  logic [2:0] async_sync_r;
  logic alt_lvl_r;
  logic async_lvl_r;
  logic half_r;
  logic [2:0] pin_sync0_r [acp_pkg::PIN_COUNT];
  logic [15:0] pin_lvl_r;

  // ************************************************************
  // decode
  // ************************************************************
  logic wr_cfg;
  logic wr_low;
  logic wr_mid;
  logic mode_change;
  logic [1:0] new_mode;
  logic [15:0] release_bits;
  logic [1:0] src_sel;
  logic src_tick;
  logic alt_rise;
  logic async_rise;
  logic [7:0] rd_mux;
  logic conv_en;

  assign wr_cfg = I_WR && (I_ADDR == acp_pkg::ADDR_CONFIG);
  assign wr_low = I_WR && (I_ADDR == acp_pkg::ADDR_PIN_LOW);
  assign wr_mid = I_WR && (I_ADDR == acp_pkg::ADDR_PIN_MID);
  assign new_mode = I_WDATA[acp_pkg::MODE_MSB:acp_pkg::MODE_LSB];
  assign mode_change = wr_cfg
    && (new_mode != cfg_r[acp_pkg::MODE_MSB:acp_pkg::MODE_LSB]);
  assign release_bits = {pin_mid_r, pin_low_r};
  assign src_sel = cfg_r[acp_pkg::SRC_MSB:acp_pkg::SRC_LSB];

  // a change counts once the second and third stages agree
  assign alt_rise = (alt_sync_r[1] == alt_sync_r[2]) && alt_sync_r[2] && !alt_lvl_r;
  assign async_rise = (async_sync_r[1] == async_sync_r[2]) && async_sync_r[2]
    && !async_lvl_r;

  // source ticks on the bus clock; slow clocks only, they are sampled
  assign src_tick = (src_sel == acp_pkg::SRC_BUS) ? 1'b1 :
    (src_sel == acp_pkg::SRC_BUS_HALF) ? half_r :
    (src_sel == acp_pkg::SRC_ALT) ? alt_rise : async_rise;

  assign rd_mux = (I_ADDR == acp_pkg::ADDR_CONFIG) ? cfg_r :
    (I_ADDR == acp_pkg::ADDR_PIN_LOW) ? pin_low_r :
    (I_ADDR == acp_pkg::ADDR_PIN_MID) ? pin_mid_r :
    {7'h00, invalid_r};

  // ************************************************************
  // converter clock divider
  // ************************************************************
  acp_clk_div acp_clk_div_i
  (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .i_tick(src_tick),
    .i_div_sel(cfg_r[acp_pkg::DIV_MSB:acp_pkg::DIV_LSB]),
    .o_clk_en(conv_en)
  );

  // ************************************************************
  // register file
  // ************************************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      cfg_r <= acp_pkg::CONFIG_RESET;
      pin_low_r <= acp_pkg::PIN_RESET;
      pin_mid_r <= acp_pkg::PIN_RESET;
      invalid_r <= 1'b0;
      O_RDATA <= 8'h00;
    end
    else
    begin
      if (wr_cfg)
        cfg_r <= I_WDATA;
      if (wr_low)
        pin_low_r <= I_WDATA;
      if (wr_mid)
        pin_mid_r <= I_WDATA;
      // set wins over the read-to-clear
      if (mode_change)
        invalid_r <= 1'b1;
      else if (I_RD && (I_ADDR == acp_pkg::ADDR_STATUS))
        invalid_r <= 1'b0;
      O_RDATA <= I_RD ? rd_mux : 8'h00;
    end
  end

  // ************************************************************
  // clock source sampling
  // ************************************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      alt_sync_r <= 3'h0;
      async_sync_r <= 3'h0;
      alt_lvl_r <= 1'b0;
      async_lvl_r <= 1'b0;
      half_r <= 1'b0;
    end
    else
    begin
      alt_sync_r <= {alt_sync_r[1:0], I_ALT_CLK};
      async_sync_r <= {async_sync_r[1:0], I_ASYNC_CLK};
      if (alt_sync_r[1] == alt_sync_r[2])
        alt_lvl_r <= alt_sync_r[2];
      if (async_sync_r[1] == async_sync_r[2])
        async_lvl_r <= async_sync_r[2];
      half_r <= ~half_r;
    end
  end

  // ************************************************************
  // per-pin control
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < acp_pkg::PIN_COUNT; g++)
    begin : g_pin
      always_ff @(posedge I_REF_CLK or negedge I_NRST)
      begin
        if (!I_NRST)
        begin
          pin_sync0_r[g] <= 3'h0;
          pin_lvl_r[g] <= 1'b0;
          O_PIN_OE[g] <= 1'b0;
          O_PIN_PULLUP[g] <= 1'b0;
          O_PIN_IBUF_EN[g] <= 1'b1;
          O_PORT_RDATA[g] <= 1'b0;
          O_ANALOG_SEL[g] <= 1'b0;
        end
        else
        begin
          pin_sync0_r[g] <= {pin_sync0_r[g][1:0], I_PIN_IN[g]};
          if (pin_sync0_r[g][1] == pin_sync0_r[g][2])
            pin_lvl_r[g] <= pin_sync0_r[g][2];
          O_ANALOG_SEL[g] <= release_bits[g];
          O_PIN_OE[g] <= I_PORT_OE[g] && !release_bits[g];
          O_PIN_PULLUP[g] <= I_PORT_PULLUP[g] && !release_bits[g];
          O_PIN_IBUF_EN[g] <= !release_bits[g];
          O_PORT_RDATA[g] <= pin_lvl_r[g] && !release_bits[g];
        end
      end
    end
  endgenerate

  // ************************************************************
  // converter core controls
  // ************************************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_LOW_POWER <= 1'b0;
      O_LONG_SAMPLE <= 1'b0;
      O_MODE <= acp_pkg::MODE_8BIT;
      O_CONV_CLK_EN <= 1'b0;
      O_RESULT_INVALID <= 1'b0;
    end
    else
    begin
      O_LOW_POWER <= cfg_r[acp_pkg::LOW_POWER_BIT];
      O_LONG_SAMPLE <= cfg_r[acp_pkg::LONG_SAMPLE_BIT];
      O_MODE <= cfg_r[acp_pkg::MODE_MSB:acp_pkg::MODE_LSB];
      O_CONV_CLK_EN <= conv_en;
      O_RESULT_INVALID <= invalid_r;
    end
  end
endmodule : acp_top

/* File: pkg/acp_pkg.sv */
// Purpose: constants for the converter configuration and pin control block
// Assumes: 8-bit registers on a plain address/strobe port
// Notes: offsets are word indices on the local port
package acp_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [1:0] ADDR_CONFIG = 2'h0;
  localparam logic [1:0] ADDR_PIN_LOW = 2'h1;
  localparam logic [1:0] ADDR_PIN_MID = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  // ************************************************************
  // configuration fields
  // ************************************************************
  localparam int LOW_POWER_BIT = 7;
  localparam int DIV_MSB = 6;
  localparam int DIV_LSB = 5;
  localparam int LONG_SAMPLE_BIT = 4;
  localparam int MODE_MSB = 3;
  localparam int MODE_LSB = 2;
  localparam int SRC_MSB = 1;
  localparam int SRC_LSB = 0;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] PIN_RESET = 8'h00;
  // ************************************************************
  // encodings
  // ************************************************************
  localparam logic [1:0] MODE_8BIT = 2'h0;
  localparam logic [1:0] MODE_10BIT = 2'h2;
  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_BUS_HALF = 2'h1;
  localparam logic [1:0] SRC_ALT = 2'h2;
  localparam logic [1:0] SRC_ASYNC = 2'h3;
  localparam int PIN_COUNT = 16;
  localparam int DIV_WIDTH = 3;
endpackage : acp_pkg

/* File: rtl/acp_clk_div.sv */
// Purpose: divides the selected source enable into the converter clock
// Assumes: source arrives as a one-cycle tick on the bus clock
// Notes: output is a one-cycle pulse on every n-th tick, n the divide ratio
`timescale 1ns/1ps
module acp_clk_div
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_tick,
  input wire logic [1:0] i_div_sel,
  output logic o_clk_en
);
  logic [acp_pkg::DIV_WIDTH-1:0] cnt_r;
  logic [acp_pkg::DIV_WIDTH-1:0] limit;
  logic hit;

  // 00 /1, 01 /2, 10 /4, 11 /8
  assign limit = acp_pkg::DIV_WIDTH'((4'h1 << i_div_sel) - 4'h1);
  assign hit = i_tick && (cnt_r >= limit);

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_r <= '0;
      o_clk_en <= 1'b0;
    end
    else
    begin
      o_clk_en <= hit;
      if (hit)
        cnt_r <= '0;
      else if (i_tick)
        cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule : acp_clk_div

/* File: verif/acp_top_props.sv */
// Purpose: port assertions for acp_top
// Assumes: a write reaches the outputs two edges after its edge
// Notes: bound from the bench top file
`timescale 1ns/1ps
module acp_top_props
(
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic [1:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [15:0] I_PORT_OE,
  input wire logic [7:0] O_RDATA,
  input wire logic [15:0] O_PIN_OE,
  input wire logic [15:0] O_PIN_PULLUP,
  input wire logic [15:0] O_PIN_IBUF_EN,
  input wire logic [15:0] O_PORT_RDATA,
  input wire logic [15:0] O_ANALOG_SEL,
  input wire logic O_LOW_POWER,
  input wire logic O_LONG_SAMPLE,
  input wire logic [1:0] O_MODE,
  input wire logic O_RESULT_INVALID
);
  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  wire cfg_w = I_WR && I_ADDR == 2'h0;
  wire low_w = I_WR && I_ADDR == 2'h1;
  wire mid_w = I_WR && I_ADDR == 2'h2;
  low_power_a: assert property (cfg_w |-> ##2 O_LOW_POWER == $past(I_WDATA[7], 2))
    else $error("low power setting wrong");
  long_sample_a: assert property (cfg_w |-> ##2 O_LONG_SAMPLE == $past(I_WDATA[4], 2))
    else $error("sample time setting wrong");
  mode_bits_a: assert property (cfg_w |-> ##2 O_MODE == $past(I_WDATA[3:2], 2))
    else $error("mode setting wrong");
  low_pins_a: assert property (low_w |-> ##2 O_ANALOG_SEL[7:0] == $past(I_WDATA, 2))
    else $error("low pin select wrong");
  mid_pins_a: assert property (mid_w |-> ##2 O_ANALOG_SEL[15:8] == $past(I_WDATA, 2))
    else $error("mid pin select wrong");
  drive_off_a: assert property ($past(I_NRST) |->
    O_PIN_OE == ($past(I_PORT_OE) & ~O_ANALOG_SEL))
    else $error("pin drive not released");
  ibuf_off_a: assert property (O_PIN_IBUF_EN == ~O_ANALOG_SEL)
    else $error("input buffer wrong");
  pull_read_a: assert property (((O_PIN_PULLUP | O_PORT_RDATA) & O_ANALOG_SEL) == 16'h0)
    else $error("pullup or port read on released pin");
  result_stale_a: assert property ($changed(O_MODE) |-> O_RESULT_INVALID)
    else $error("mode change left result valid");
  read_idle_a: assert property (!I_RD |=> O_RDATA == 8'h00)
    else $error("read data outside read cycle");
  cover property (cfg_w && I_WDATA[3:2] == 2'h2);
  cover property (I_RD && I_ADDR == 2'h3);
  cover property ($rose(O_ANALOG_SEL[15]));
endmodule : acp_top_props

/* File: verif/acp_pins.sv */
// Purpose: port logic and clock sources facing acp_top
// Assumes: one mask from the bench sets port wishes and pin levels alike
// Notes: alternate clock period 16 cycles, internal clock 8
`timescale 1ns/1ps
module acp_pins
(
  input wire logic i_clk,
  input wire logic [15:0] i_port_mask,
  output logic o_alt_clk,
  output logic o_async_clk,
  output logic [15:0] o_port_oe,
  output logic [15:0] o_port_pullup,
  output logic [15:0] o_pin_in
);
  // ************************************************************
  // sources
  // ************************************************************
  logic [3:0] cnt_r = 4'h0;
  always @(posedge i_clk) cnt_r <= cnt_r + 4'h1;
  assign o_alt_clk = cnt_r[3];
  assign o_async_clk = cnt_r[2];
  // one mask for all three so a released pin can only show as a zero
  assign o_port_oe = i_port_mask;
  assign o_port_pullup = i_port_mask;
  assign o_pin_in = i_port_mask;
endmodule : acp_pins

/* File: verif/adc_config_and_pin_control_bench.sv */
// Purpose: self-checking bench for acp_top
// Assumes: acp_pins holds every port wish and pin high until the mask drops to 0FF0 near the end
// Notes: pulse counts use a 64-cycle window with one of slack
`timescale 1ns/1ps
module adc_config_and_pin_control_bench;
  typedef struct {logic [1:0] a; logic [7:0] d; int p;} acp_row_t;
  logic clk, nrst, wstb, rstb, alt, asy, clk_en, lp, ls, inv;
  logic [1:0] addr, mode;
  logic [7:0] wdata, rdata, got;
  logic [15:0] poe, ppu, pin, oe, pu, ibuf, prd, sel, es, pm;
  int miscompares, comparisons, n;
  acp_row_t rows[14] = '{'{0, 8'h00, 64}, '{0, 8'h20, 32}, '{0, 8'h48, 16},
    '{0, 8'hE0, 8}, '{0, 8'h91, 32}, '{0, 8'h61, 4}, '{0, 8'h02, 4}, '{0, 8'h03, 8},
    '{0, 8'h23, 4}, '{0, 8'h0C, 64}, '{1, 8'h81, -1}, '{2, 8'h81, -1},
    '{1, 8'h00, -1}, '{2, 8'h5A, -1}};
  acp_top acp_top_i (.I_REF_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wstb), .I_RD(rstb), .O_RDATA(rdata), .I_ALT_CLK(alt), .I_ASYNC_CLK(asy),
    .I_PORT_OE(poe), .I_PORT_PULLUP(ppu), .I_PIN_IN(pin), .O_PIN_OE(oe), .O_PIN_PULLUP(pu),
    .O_PIN_IBUF_EN(ibuf), .O_PORT_RDATA(prd), .O_ANALOG_SEL(sel), .O_LOW_POWER(lp),
    .O_LONG_SAMPLE(ls), .O_MODE(mode), .O_CONV_CLK_EN(clk_en), .O_RESULT_INVALID(inv));
  acp_pins acp_pins_i (.i_clk(clk), .i_port_mask(pm), .o_alt_clk(alt), .o_async_clk(asy),
    .o_port_oe(poe),
    .o_port_pullup(ppu), .o_pin_in(pin));
  // ************************************************************
  // tasks
  // ************************************************************
  task chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wstb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wstb <= 1'b0;
  endtask : bus_wr
  task bus_rd(input logic [1:0] a);
    @(posedge clk);
    rstb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rstb <= 1'b0;
    #1 got = rdata;
  endtask : bus_rd
  task pulses(input int e);
    n = 0;
    repeat (64) @(negedge clk) n += int'(clk_en);
    chk(16'(n >= e - 1 && n <= e + 1), 16'h1);
  endtask : pulses
  task rst;
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(ibuf, 16'hFFFF);
    nrst <= 1'b1;
    bus_rd(2'h0);
    chk(got, 8'h00);
    pulses(64);
  endtask : rst
  task end_sim;
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #100000 miscompares++;
    end_sim;
  end
  initial
  begin
    {nrst, wstb, rstb, addr, wdata, es} = '0;
    pm = 16'hFFFF;
    @(posedge clk);
    rst;
    foreach (rows[i])
    begin
      bus_wr(rows[i].a, rows[i].d);
      bus_rd(rows[i].a);
      chk(got, rows[i].d);
      repeat (8) @(posedge clk);
      if (rows[i].p >= 0)
      begin
        chk({lp, ls, mode}, {rows[i].d[7], rows[i].d[4], rows[i].d[3:2]});
        pulses(rows[i].p);
      end
      else
      begin
        if (rows[i].a == 2'h1)
          es[7:0] = rows[i].d;
        else
          es[15:8] = rows[i].d;
        chk(sel, es);
        chk(oe & pu & prd & ibuf, ~es);
        chk(oe | pu | prd | ibuf, ~es);
      end
    end
    // mode change flags stale results, other changes and index 3 writes do not
    bus_wr(2'h0, 8'h08);
    bus_rd(2'h3);
    chk(got[0], 1'b1);
    bus_wr(2'h0, 8'h09);
    bus_wr(2'h3, 8'hFF);
    bus_rd(2'h3);
    chk(got[0], 1'b0);
    bus_wr(2'h0, 8'h01);
    bus_rd(2'h3);
    chk(got[0], 1'b1);
    chk(inv, 1'b1);
    bus_rd(2'h3);
    chk(got[0], 1'b0);
    // port wishes and pin levels that differ from pin to pin
    @(posedge clk);
    pm <= 16'h0FF0;
    repeat (8) @(posedge clk);
    chk(oe, pm & ~es);
    chk(pu, pm & ~es);
    chk(prd, pm & ~es);
    // let the write land before reset, so reset has something to clear
    bus_wr(2'h1, 8'hFF);
    repeat (2) @(posedge clk);
    chk(sel, {es[15:8], 8'hFF});
    rst;
    chk(sel, 16'h0000);
    end_sim;
  end
endmodule : adc_config_and_pin_control_bench
bind acp_top acp_top_props acp_top_props_i (.I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_PORT_OE(I_PORT_OE),
  .O_RDATA(O_RDATA), .O_PIN_OE(O_PIN_OE), .O_PIN_PULLUP(O_PIN_PULLUP),
  .O_PIN_IBUF_EN(O_PIN_IBUF_EN), .O_PORT_RDATA(O_PORT_RDATA), .O_ANALOG_SEL(O_ANALOG_SEL),
  .O_LOW_POWER(O_LOW_POWER), .O_LONG_SAMPLE(O_LONG_SAMPLE), .O_MODE(O_MODE),
  .O_RESULT_INVALID(O_RESULT_INVALID));
